// *** src/tscap_regs.sv ***
// Timestamp capture register bank with its control and status registers.
// Assumes a synchronous register port, calendar counters stable in each cycle
// and trigger pulses already detected and synchronised.
//
// Function
// - Seconds BCD, tens 6:4, units 3:0
// - Minutes BCD, tens 6:4, units 3:0
// - 12-hour: meridian bit 5, tens bit 4
// - 24-hour: tens bits 5:4, units 3:0
// - Hour-format control bit selects hours layout
// - Day BCD, tens 5:4, units 3:0
// - Month BCD, tens bit 4, units 3:0
// - Year BCD uses all eight bits
// - Unimplemented capture bits read as zero
// - Captured fields never reset, undefined at power-on
// - Accepted trigger copies calendar into captures
// - Mode bit: overwrite latest or keep first
// - Capture enabled at power-on, disable bit stops pin capture only
// - Battery switch capture then sets battery flag
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module tscap_regs
    import tscap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // Calendar counters
    input wire logic [6:0] cal_seconds,
    input wire logic [6:0] cal_minutes,
    input wire logic cal_meridian_indicator,
    input wire logic [5:0] cal_hours,
    input wire logic [5:0] cal_day,
    input wire logic [4:0] cal_month,
    input wire logic [7:0] cal_year,
    // Events
    input wire logic capture_trigger_pin,
    input wire logic switch_event,
    // Status
    output logic captured,
    output logic battery_switch_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    tscap_cal_s cal;
    tscap_req_s req;
    logic [7:0] ctrl;
    logic [7:0] cap_seconds;
    logic [7:0] cap_minutes;
    logic [7:0] cap_hours;
    logic [7:0] cap_day;
    logic [7:0] cap_month;
    logic [7:0] cap_year;
    logic [7:0] hours_field;
    logic take_pin;
    logic take_switch;
    logic take_any;
    logic ctrl_wr;
    logic status_wr;
    logic [7:0] next_rdata;

    assign cal = '{seconds: cal_seconds, minutes: cal_minutes,
                   meridian_indicator: cal_meridian_indicator, hours: cal_hours,
                   day: cal_day, month: cal_month, year: cal_year};
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign ctrl_wr = req.wr && hit(req.addr, OFS_CAP_CTRL);
    assign status_wr = req.wr && hit(req.addr, OFS_CAP_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Event qualification and hour layout

    tscap_event u_event (
        .keep_first (ctrl[CTRL_KEEP_FIRST_BIT]),
        .capture_disable (ctrl[CTRL_DISABLE_BIT]),
        .battery_switch_capture_enable (ctrl[CTRL_BATT_EN_BIT]),
        .battery_switch_flag (battery_switch_flag),
        .captured (captured),
        .pin_event (capture_trigger_pin),
        .switch_event (switch_event),
        .take_pin (take_pin),
        .take_switch (take_switch)
    );

    assign take_any = take_pin || take_switch;

    tscap_hour_fmt u_hour (
        .hour12 (ctrl[CTRL_HOUR12_BIT]),
        .meridian_indicator (cal.meridian_indicator),
        .hours_bcd (cal.hours),
        .hours_field (hours_field)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl <= CTRL_RESET;
        else if (ctrl_wr)
            ctrl <= {4'h0, req.wdata[3:0]};
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags: hardware set wins over software clear

    always_ff @(posedge clk)
    begin
        if (rst)
            captured <= STATUS_RESET;
        else if (take_any)
            captured <= 1'b1;
        else if (status_wr && !req.wdata[STAT_CAPTURED_BIT])
            captured <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            battery_switch_flag <= STATUS_RESET;
        else if (take_switch)
            battery_switch_flag <= 1'b1;
        else if (status_wr && !req.wdata[STAT_BATT_FLAG_BIT])
            battery_switch_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture registers, deliberately without reset

    always_ff @(posedge clk)
    begin
        if (take_any)
        begin
            cap_seconds <= {1'b0, cal.seconds};
            cap_minutes <= {1'b0, cal.minutes};
            cap_hours <= hours_field;
            cap_day <= {2'h0, cal.day};
            cap_month <= {3'h0, cal.month};
            cap_year <= cal.year;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb
    begin
        next_rdata = READ_ZERO;
        case (req.addr)
            OFS_CAP_SECONDS: next_rdata = cap_seconds & MASK_SECONDS;
            OFS_CAP_MINUTES: next_rdata = cap_minutes & MASK_MINUTES;
            OFS_CAP_HOURS: next_rdata = cap_hours & MASK_HOURS;
            OFS_CAP_DAY: next_rdata = cap_day & MASK_DAY;
            OFS_CAP_MONTH: next_rdata = cap_month & MASK_MONTH;
            OFS_CAP_YEAR: next_rdata = cap_year & MASK_YEAR;
            OFS_CAP_CTRL: next_rdata = ctrl;
            OFS_CAP_STATUS: next_rdata = {6'h00, battery_switch_flag, captured};
            default: next_rdata = READ_ZERO;
        endcase
    end

    // Data only in the cycle after the read strobe
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= READ_ZERO;
        else if (req.rd)
            rdata <= next_rdata;
        else
            rdata <= READ_ZERO;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_sec;
        @(posedge clk) disable iff (rst)
        take_any |=> cap_seconds == {1'b0, $past(cal_seconds)};
    endproperty
    sec_capture_a: assert property (p_sec) else $error("seconds not captured");

    min_capture_a: assert property (@(posedge clk) disable iff (rst)
        take_any |=> cap_minutes[6:0] == $past(cal_minutes)) else $error("minutes not captured");

    hour12_layout_a: assert property (@(posedge clk) disable iff (rst)
        take_any && ctrl[CTRL_HOUR12_BIT] |=> cap_hours[MERIDIAN_BIT] == $past(cal_meridian_indicator)
        && cap_hours[7:6] == 2'h0) else $error("12-hour layout wrong");

    hour24_layout_a: assert property (@(posedge clk) disable iff (rst)
        take_any && !ctrl[CTRL_HOUR12_BIT] |=> cap_hours[5:0] == $past(cal_hours))
        else $error("24-hour layout wrong");

    day_capture_a: assert property (@(posedge clk) disable iff (rst)
        take_any |=> cap_day == {2'h0, $past(cal_day)}) else $error("day not captured");

    month_year_a: assert property (@(posedge clk) disable iff (rst)
        take_any |=> cap_month[4:0] == $past(cal_month) && cap_year == $past(cal_year))
        else $error("month or year not captured");

    zero_bits_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CAP_HOURS |=> rdata[7:6] == 2'h0) else $error("unused hour bits not zero");

    hold_capture_a: assert property (@(posedge clk) disable iff (rst)
        !take_any |=> $stable(cap_year) && $stable(cap_seconds)) else $error("capture changed without event");

    keep_first_a: assert property (@(posedge clk) disable iff (rst)
        ctrl[CTRL_KEEP_FIRST_BIT] && captured |-> !take_any) else $error("first event overwritten");

    disable_a: assert property (@(posedge clk) disable iff (rst)
        ctrl[CTRL_DISABLE_BIT] |-> !take_pin) else $error("capture while disabled");

    batt_flag_a: assert property (@(posedge clk) disable iff (rst)
        take_switch |=> battery_switch_flag ##1 1'b1) else $error("battery flag not set");

    ////////////////////////////////////////////////////////////////////////
    // Event qualification checks

    captured_set_a: assert property (@(posedge clk) disable iff (rst)
        take_any
        |=> captured)
        else $error("captured flag not set");

    pin_take_a: assert property (@(posedge clk) disable iff (rst)
        capture_trigger_pin && !ctrl[CTRL_DISABLE_BIT] && !(ctrl[CTRL_KEEP_FIRST_BIT] && captured)
        && !(ctrl[CTRL_BATT_EN_BIT] && battery_switch_flag) |-> take_pin)
        else $error("pin trigger lost");

    no_event_a: assert property (@(posedge clk) disable iff (rst)
        !capture_trigger_pin && !switch_event
        |-> !take_any)
        else $error("capture without trigger");

    overwrite_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl[CTRL_KEEP_FIRST_BIT] && capture_trigger_pin && !ctrl[CTRL_DISABLE_BIT]
        && !(ctrl[CTRL_BATT_EN_BIT] && battery_switch_flag) |-> take_any)
        else $error("latest event not taken");

    status_clear_a: assert property (@(posedge clk) disable iff (rst)
        status_wr && !wdata[STAT_CAPTURED_BIT] && !take_any
        |=> !captured)
        else $error("captured flag not cleared");

    switch_take_a: assert property (@(posedge clk) disable iff (rst)
        switch_event && ctrl[CTRL_BATT_EN_BIT] && !battery_switch_flag
        && !(ctrl[CTRL_KEEP_FIRST_BIT] && captured) |-> take_switch)
        else $error("switch event lost");

    switch_off_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl[CTRL_BATT_EN_BIT]
        |-> !take_switch)
        else $error("switch capture while off");

    flag_blocks_a: assert property (@(posedge clk) disable iff (rst)
        ctrl[CTRL_BATT_EN_BIT] && battery_switch_flag
        |-> !take_any)
        else $error("capture while battery flag set");

    batt_clear_a: assert property (@(posedge clk) disable iff (rst)
        status_wr && !wdata[STAT_BATT_FLAG_BIT] && !take_switch
        |=> !battery_switch_flag)
        else $error("battery flag not cleared");

    ////////////////////////////////////////////////////////////////////////
    // Capture content checks

    hour12_digits_a: assert property (@(posedge clk) disable iff (rst)
        take_any && ctrl[CTRL_HOUR12_BIT]
        |=> cap_hours[4:0] == $past(cal_hours[4:0]))
        else $error("12-hour digits wrong");

    hour24_top_a: assert property (@(posedge clk) disable iff (rst)
        take_any && !ctrl[CTRL_HOUR12_BIT]
        |=> cap_hours[7:6] == 2'h0)
        else $error("24-hour unused bits set");

    coherent_a: assert property (@(posedge clk) disable iff (rst)
        take_any
        |=> cap_minutes == {1'b0, $past(cal_minutes)} && cap_month == {3'h0, $past(cal_month)})
        else $error("fields from different instants");

    hold_rest_a: assert property (@(posedge clk) disable iff (rst)
        !take_any
        |=> $stable(cap_minutes) && $stable(cap_hours) && $stable(cap_day) && $stable(cap_month))
        else $error("capture changed without event");

    ////////////////////////////////////////////////////////////////////////
    // Read path checks

    sec_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CAP_SECONDS
        |=> rdata[7] == 1'b0)
        else $error("unused seconds bit set");

    min_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CAP_MINUTES
        |=> rdata[7] == 1'b0)
        else $error("unused minutes bit set");

    day_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CAP_DAY
        |=> rdata[7:6] == 2'h0)
        else $error("unused day bits set");

    month_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CAP_MONTH
        |=> rdata[7:5] == 3'h0)
        else $error("unused month bits set");

    year_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CAP_YEAR
        |=> rdata == $past(cap_year))
        else $error("year read wrong");

    rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
        !rd
        |=> rdata == READ_ZERO)
        else $error("read data outside read cycle");

endmodule

// *** src/tscap_pkg.sv ***
// Package for the timestamp capture register bank: offsets, field layouts,
// control bit positions and shared carriers.
// Assumes an 8-bit register port with byte offsets as printed.
package tscap_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Capture registers (read only)
    localparam logic [7:0] OFS_CAP_SECONDS = 8'h13;
    localparam logic [7:0] OFS_CAP_MINUTES = 8'h14;
    localparam logic [7:0] OFS_CAP_HOURS = 8'h15;
    localparam logic [7:0] OFS_CAP_DAY = 8'h16;
    localparam logic [7:0] OFS_CAP_MONTH = 8'h17;
    localparam logic [7:0] OFS_CAP_YEAR = 8'h18;

    // Control registers of this bank
    localparam logic [7:0] OFS_CAP_CTRL = 8'h30;
    localparam logic [7:0] OFS_CAP_STATUS = 8'h31;

    // Control register bit positions
    localparam int CTRL_KEEP_FIRST_BIT = 0;
    localparam int CTRL_DISABLE_BIT = 1;
    localparam int CTRL_BATT_EN_BIT = 2;
    localparam int CTRL_HOUR12_BIT = 3;

    // Status register bit positions
    localparam int STAT_CAPTURED_BIT = 0;
    localparam int STAT_BATT_FLAG_BIT = 1;

    // Reset values of control and status
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic STATUS_RESET = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Valid bit masks of the capture registers
    localparam logic [7:0] MASK_SECONDS = 8'h7F;
    localparam logic [7:0] MASK_MINUTES = 8'h7F;
    localparam logic [7:0] MASK_HOURS = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam int MERIDIAN_BIT = 5;

    // Calendar counter snapshot, all BCD
    typedef struct packed {
        logic [6:0] seconds;
        logic [6:0] minutes;
        logic meridian_indicator;
        logic [5:0] hours;
        logic [5:0] day;
        logic [4:0] month;
        logic [7:0] year;
    } tscap_cal_s;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tscap_req_s;

endpackage

// *** src/tscap_hour_fmt.sv ***
// Hour field formatter: lays the sampled hour into the 12- or 24-hour form.
// Assumes the calendar core delivers hours already in the selected format.
`timescale 1ns/1ps
module tscap_hour_fmt
    import tscap_pkg::*;
(
    // Inputs
    input wire logic hour12,
    input wire logic meridian_indicator,
    input wire logic [5:0] hours_bcd,
    // Output
    output logic [7:0] hours_field
);

    always_comb
    begin
        if (hour12)
        begin
            hours_field = READ_ZERO;
            hours_field[MERIDIAN_BIT] = meridian_indicator;
            hours_field[4:0] = hours_bcd[4:0];
        end
        else
        begin
            hours_field = {2'h0, hours_bcd};
        end
    end

endmodule

// *** src/tscap_event.sv ***
// Capture event qualifier: decides when a snapshot is taken.
// Assumes trigger inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module tscap_event
    import tscap_pkg::*;
(
    // Controls
    input wire logic keep_first,
    input wire logic capture_disable,
    input wire logic battery_switch_capture_enable,
    input wire logic battery_switch_flag,
    input wire logic captured,
    // Events
    input wire logic pin_event,
    input wire logic switch_event,
    // Results
    output logic take_pin,
    output logic take_switch
);

    logic keep_blocks;

    // A held first event is protected until software clears the flag
    assign keep_blocks = keep_first && captured;

    // A set battery flag blocks pin and switch captures while enabled
    always_comb
    begin
        take_switch = switch_event && battery_switch_capture_enable && !battery_switch_flag && !keep_blocks;
        take_pin = pin_event && !capture_disable && !keep_blocks
            && !(battery_switch_capture_enable && battery_switch_flag);
    end

endmodule

// *** dv/tb.sv ***
// Self-checking bench for the timestamp capture register bank.
// Assumes the bench plays both the calendar core and the register host.
`timescale 1ns/1ps
module tb;
    import tscap_pkg::*;
    logic clk, rst, wr, rd, pin, sw, mer, cap, bflag;
    logic [7:0] addr, wdata, rdata, yr, got;
    logic [6:0] sec, mnt;
    logic [5:0] hr, dy;
    logic [4:0] mon;
    logic [7:0] e [6];
    logic [7:0] k [6];
    int n_errors = 0;
    int n_compared = 0;

    tscap_regs i_tscap_regs (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cal_seconds(sec), .cal_minutes(mnt), .cal_meridian_indicator(mer),
        .cal_hours(hr), .cal_day(dy), .cal_month(mon), .cal_year(yr), .capture_trigger_pin(pin),
        .switch_event(sw), .captured(cap), .battery_switch_flag(bflag));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        got = rdata;
    endtask

    // Seconds and year are scrambled at the capture edge, so a late sample shows up
    task automatic fire(input logic is_sw);
        @(posedge clk);
        pin <= ~is_sw;
        sw <= is_sw;
        @(posedge clk);
        pin <= 1'b0;
        sw <= 1'b0;
        sec <= ~sec;
        yr <= ~yr;
    endtask

    task automatic set_cal(input logic [7:0] s, m, h, d, mo, y, input logic me, h12);
        @(posedge clk);
        sec <= s[6:0];
        mnt <= m[6:0];
        hr <= h[5:0];
        dy <= d[5:0];
        mon <= mo[4:0];
        yr <= y;
        mer <= me;
        e[0] = {1'b0, s[6:0]};
        e[1] = {1'b0, m[6:0]};
        e[2] = h12 ? {2'b00, me, h[4:0]} : {2'b00, h[5:0]};
        e[3] = {2'b00, d[5:0]};
        e[4] = {3'b000, mo[4:0]};
        e[5] = y;
    endtask

    task automatic chk_caps();
        for (int i = 0; i < 6; i++)
        begin
            rd_reg(OFS_CAP_SECONDS + 8'(i));
            check("capture", e[i], got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("captured", 8'h00, {7'h00, cap});
        check("batt flag", 8'h00, {7'h00, bflag});
        rd_reg(OFS_CAP_CTRL);
        check("ctrl", CTRL_RESET, got);
        rd_reg(8'h40);
        check("unmapped", 8'h00, got);
        @(posedge clk);
        #1;
        check("rdata idle", 8'h00, rdata);
        $display("test reset done");
    endtask

    task automatic t_cap24();
        set_cal(8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 1'b1, 1'b0);
        fire(1'b0);
        #1;
        check("captured", 8'h01, {7'h00, cap});
        chk_caps();
        wr_reg(OFS_CAP_SECONDS, 8'h00);
        wr_reg(OFS_CAP_YEAR, 8'h00);
        chk_caps();
        $display("test capture 24-hour done");
    endtask

    task automatic t_cap12();
        wr_reg(OFS_CAP_CTRL, 8'h08);
        set_cal(8'h07, 8'h30, 8'h31, 8'h01, 8'h10, 8'h00, 1'b0, 1'b1);
        fire(1'b0);
        chk_caps();
        set_cal(8'h00, 8'h00, 8'h12, 8'h20, 8'h09, 8'h45, 1'b1, 1'b1);
        fire(1'b0);
        chk_caps();
        wr_reg(OFS_CAP_CTRL, 8'h00);
        set_cal(8'h00, 8'h00, 8'h12, 8'h20, 8'h09, 8'h45, 1'b1, 1'b0);
        fire(1'b0);
        chk_caps();
        $display("test capture 12-hour done");
    endtask

    task automatic t_mode();
        wr_reg(OFS_CAP_CTRL, 8'h01);
        wr_reg(OFS_CAP_STATUS, 8'h00);
        set_cal(8'h11, 8'h22, 8'h03, 8'h04, 8'h05, 8'h06, 1'b0, 1'b0);
        fire(1'b0);
        k = e;
        set_cal(8'h33, 8'h44, 8'h15, 8'h16, 8'h11, 8'h27, 1'b0, 1'b0);
        fire(1'b0);
        e = k;
        chk_caps();
        wr_reg(OFS_CAP_CTRL, 8'h00);
        set_cal(8'h33, 8'h44, 8'h15, 8'h16, 8'h11, 8'h27, 1'b0, 1'b0);
        fire(1'b0);
        chk_caps();
        $display("test capture mode done");
    endtask

    task automatic t_disable();
        wr_reg(OFS_CAP_CTRL, 8'h02);
        wr_reg(OFS_CAP_STATUS, 8'h00);
        k = e;
        set_cal(8'h01, 8'h02, 8'h03, 8'h04, 8'h01, 8'h02, 1'b0, 1'b0);
        fire(1'b0);
        #1;
        check("captured", 8'h00, {7'h00, cap});
        e = k;
        chk_caps();
        $display("test disable done");
    endtask

    task automatic t_batt();
        wr_reg(OFS_CAP_CTRL, 8'h04);
        set_cal(8'h45, 8'h12, 8'h08, 8'h28, 8'h02, 8'h24, 1'b0, 1'b0);
        fire(1'b1);
        #1;
        check("batt flag", 8'h01, {7'h00, bflag});
        chk_caps();
        k = e;
        set_cal(8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 1'b0, 1'b0);
        fire(1'b1);
        fire(1'b0);
        e = k;
        chk_caps();
        rd_reg(OFS_CAP_STATUS);
        check("status", 8'h03, got);
        wr_reg(OFS_CAP_STATUS, 8'h01);
        wr_reg(OFS_CAP_CTRL, 8'h00);
        fire(1'b1);
        rd_reg(OFS_CAP_STATUS);
        check("status", 8'h01, got);
        chk_caps();
        $display("test battery switch done");
    endtask

    task automatic t_rst();
        k = e;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFS_CAP_STATUS);
        check("status", 8'h00, got);
        e = k;
        chk_caps();
        $display("test reset keeps captures done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        {rst, wr, rd, pin, sw, mer, addr, wdata, sec, mnt, hr, dy, mon, yr} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_cap24();
        t_cap12();
        t_mode();
        t_disable();
        t_batt();
        t_rst();
        give_verdict();
    end
endmodule
